// *** arm_consts.svh ***
// Notes on behaviour
// - Every clock destination is driven by one source picked by its 5-bit field.
// - Clock codes 0x0-0x13 pick pin buffers 1-20, 0x14-0x19 serial port clocks 0-5.
// - Clock code 0x1A picks S/PDIF receive clock, 0x1B its TDM clock.
// - Clock code 0x1C picks precision clock A, 0x1D precision clock B.
// - Codes 0x1E/0x1F (5-bit) and 0x3E/0x3F (6-bit) give constant low/high.
// - External clock sources of generators A/B come from bits 0-4 and 5-9.
// - Serial ports 6 and 7 take routed clocks but offer no clock codes.
// - Data group feeds serial port A/B data inputs and input data port.
// - Data uses 6-bit codes; 0x0-0x13 pins, 0x14-0x1F port 0-5 A/B data.
// - Data codes 0x20-0x23 converter data, 0x24-0x27 converter TDM, 0x28 receiver data.
// - Data codes 0x2C-0x2F ports 6/7 A/B data, 0x30 transmitter biphase; 0x31-0x3D reserved.
// - Frame sync group delivers frame syncs to ports, converters, S/PDIF, input port.
// - Frame sync 5-bit codes: pins, port 0-5 syncs, 0x1A receiver sync, 0x1B reserved.
// - Frame sync code 0x1C picks generator A sync, 0x1D generator B sync.
// - Frame syncs of serial ports 6 and 7 have no internal frame sync code.
// - Each of 20 pin buffers takes its output from a 7-bit assignment code.
// - Bit 28 of fifth pin register inverts pin 19 input, bit 29 pin 20.
// - Inversion applies only when that pin is not routed to its own input.
// - Pin codes 0x0-0x13 pick pins, 0x45 biphase out, 0x7E low, 0x7F high.
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses, one word each)
// ****************************************************************
`define ARM_ADDR_W        8
`define ARM_NUM_REGS      23
`define ARM_CLK_BASE      8'h00
`define ARM_DAT_BASE      8'h18
`define ARM_FS_BASE       8'h30
`define ARM_PIN_BASE      8'h44
`define ARM_STATUS_OFS    8'h58
`define ARM_CLK_IDX0      0
`define ARM_CLK_REGS      6
`define ARM_DAT_IDX0      6
`define ARM_DAT_REGS      6
`define ARM_FS_IDX0       12
`define ARM_FS_REGS       5
`define ARM_PIN_IDX0      17
`define ARM_PIN_REGS      5
`define ARM_STATUS_IDX    22

// ****************************************************************
// Field layout
// ****************************************************************
`define ARM_CLK_FW        5
`define ARM_CLK_FPR       6
`define ARM_DAT_FW        6
`define ARM_DAT_FPR       5
`define ARM_FS_FW         5
`define ARM_FS_FPR        6
`define ARM_PIN_FW        7
`define ARM_PIN_FPR       4
`define ARM_NUM_PINS      20
`define ARM_INV19_BIT     28
`define ARM_INV20_BIT     29
`define ARM_PCGA_FIELD    0
`define ARM_PCGB_FIELD    1
`define ARM_MASK30        32'h3fffffff
`define ARM_MASK28        32'h0fffffff
`define ARM_MASK_STATUS   32'h00000003

// ****************************************************************
// Reset values: every destination parked at constant low
// ****************************************************************
`define ARM_CLK_RST       32'h3def7bde
`define ARM_DAT_RST       32'h3efbefbe
`define ARM_FS_RST        32'h3def7bde
`define ARM_PIN_RST       32'h0fdfbf7e

`endif

// *** arm_pkg.sv ***
`include "arm_consts.svh"

package arm_pkg;

  typedef logic [31:0]              arm_word_t;
  typedef logic [`ARM_ADDR_W-1:0]   arm_addr_t;

  // All state of the routing matrix
  typedef struct packed {
    logic [`ARM_NUM_REGS-1:0][31:0] regs;
    logic [31:0]                    rd_data;
  } arm_state_s;

endpackage

// *** arm_routing_matrix.sv ***
`timescale 1ns/1ns
`include "arm_consts.svh"

module arm_routing_matrix #(
  parameter int NUM_PINS = `ARM_NUM_PINS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Register port
  input  wire arm_pkg::arm_addr_t    addr,
  input  wire arm_pkg::arm_word_t    wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output arm_pkg::arm_word_t         rd_data,
  // Sources: pins and peripheral outputs
  input  wire logic [19:0]           pin_in,
  input  wire logic [7:0]            serial_port_clock_out,
  input  wire logic [7:0]            serial_port_frame_sync_out,
  input  wire logic [7:0]            serial_port_data_a_out,
  input  wire logic [7:0]            serial_port_data_b_out,
  input  wire logic [7:0]            serial_port_tx_valid_out,
  input  wire logic [3:0]            rate_converter_data_out,
  input  wire logic [3:0]            rate_converter_tdm_out,
  input  wire logic                  spdif_rx_clock_out,
  input  wire logic                  spdif_rx_tdm_clock_out,
  input  wire logic                  spdif_rx_data_out,
  input  wire logic                  spdif_rx_frame_sync_out,
  input  wire logic                  spdif_rx_lrclk_ref_out,
  input  wire logic                  spdif_rx_lrclk_fb_out,
  input  wire logic                  spdif_tx_biphase_out,
  input  wire logic                  spdif_tx_block_start_out,
  input  wire logic                  parallel_strobe_out,
  input  wire logic [3:0]            precision_clock_out,
  input  wire logic [3:0]            precision_frame_sync_out,
  // Routed destinations
  output logic [35:0]                clock_route_out,
  output logic [29:0]                data_route_out,
  output logic [29:0]                frame_sync_route_out,
  output logic [19:0]                pin_buffer_out,
  output logic                       pcg_ext_clock_a,
  output logic                       pcg_ext_clock_b
);
  import arm_pkg::*;

  localparam int NCLK = `ARM_CLK_REGS * `ARM_CLK_FPR;
  localparam int NDAT = `ARM_DAT_REGS * `ARM_DAT_FPR;
  localparam int NFS  = `ARM_FS_REGS * `ARM_FS_FPR;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Write mask per register index; reserved bits never store
  function automatic logic [31:0] reg_mask(input logic [5:0] idx);
    logic [31:0] m;
    m = 32'h00000000;
    if (idx < 6'(`ARM_PIN_IDX0))
      m = `ARM_MASK30;
    else if (idx == 6'(`ARM_PIN_IDX0 + `ARM_PIN_REGS - 1))
      m = `ARM_MASK30;
    else if (idx < 6'(`ARM_STATUS_IDX))
      m = `ARM_MASK28;
    return m;
  endfunction

  // Picks one bit of a source vector by code
  function automatic logic pick32(input logic [31:0] v, input logic [4:0] s);
    return v[s];
  endfunction

  function automatic logic pick64(input logic [63:0] v, input logic [5:0] s);
    return v[s];
  endfunction

  function automatic logic pick128(input logic [127:0] v, input logic [6:0] s);
    return v[s];
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  arm_state_s  st_r;
  arm_state_s  st_nxt;
  logic [5:0]  wr_idx;
  logic        addr_ok;
  logic [31:0] status_word;
  logic        inv19_active;
  logic        inv20_active;

  assign wr_idx  = addr[7:2];
  // Misaligned or out-of-range words are ignored and read as zero
  assign addr_ok = (addr[1:0] == 2'b00) && (wr_idx < 6'(`ARM_NUM_REGS));

  // Next state: write masked, read captured for one cycle only
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rd_data = 32'h00000000;
    if (wr_en && addr_ok && (wr_idx != 6'(`ARM_STATUS_IDX))) begin
      st_nxt.regs[wr_idx] = wr_data & reg_mask(wr_idx);
    end
    if (rd_en && addr_ok) begin
      if (wr_idx == 6'(`ARM_STATUS_IDX))
        st_nxt.rd_data = status_word;
      else
        st_nxt.rd_data = st_r.regs[wr_idx] & reg_mask(wr_idx);
    end
  end

  // Reset parks all destinations on constant low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `ARM_NUM_REGS; i++) begin
        if (i < `ARM_DAT_IDX0)
          st_r.regs[i] <= `ARM_CLK_RST;
        else if (i < `ARM_FS_IDX0)
          st_r.regs[i] <= `ARM_DAT_RST;
        else if (i < `ARM_PIN_IDX0)
          st_r.regs[i] <= `ARM_FS_RST;
        else if (i < `ARM_STATUS_IDX)
          st_r.regs[i] <= `ARM_PIN_RST;
        else
          st_r.regs[i] <= 32'h00000000;
      end
      st_r.rd_data <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;

  // ****************************************************************
  // Pin input inversion
  // ****************************************************************
  localparam int PIN4_IDX = `ARM_PIN_IDX0 + `ARM_PIN_REGS - 1;
  localparam logic [6:0] PIN19_CODE = 7'h12;
  localparam logic [6:0] PIN20_CODE = 7'h13;

  logic [6:0]  pin19_sel;
  logic [6:0]  pin20_sel;
  logic [19:0] pin_src;

  assign pin19_sel = st_r.regs[PIN4_IDX][2*`ARM_PIN_FW +: `ARM_PIN_FW];
  assign pin20_sel = st_r.regs[PIN4_IDX][3*`ARM_PIN_FW +: `ARM_PIN_FW];

  // A pin looped onto itself keeps its true level to avoid a ring
  assign inv19_active = st_r.regs[PIN4_IDX][`ARM_INV19_BIT]
                        && (pin19_sel != PIN19_CODE);
  assign inv20_active = st_r.regs[PIN4_IDX][`ARM_INV20_BIT]
                        && (pin20_sel != PIN20_CODE);

  // Level seen by the matrix from each pin
  always_comb begin
    pin_src     = pin_in;
    pin_src[18] = pin_in[18] ^ inv19_active;
    pin_src[19] = pin_in[19] ^ inv20_active;
  end

  assign status_word = {30'h0, inv20_active, inv19_active};

  // ****************************************************************
  // Source vectors, indexed by selection code
  // ****************************************************************
  logic [31:0]  clk_src;
  logic [63:0]  dat_src;
  logic [31:0]  fs_src;
  logic [127:0] pin_assign_src;

  // Clock group; ports 6 and 7 have no code here
  assign clk_src = {1'b1, 1'b0,
                    precision_clock_out[1],
                    precision_clock_out[0],
                    spdif_rx_tdm_clock_out,
                    spdif_rx_clock_out,
                    serial_port_clock_out[5:0],
                    pin_src};

  // Data group interleaves A and B per port
  always_comb begin
    dat_src        = 64'h0000000000000000; // Reserved codes read low
    dat_src[19:0]  = pin_src;
    for (int p = 0; p < 6; p++) begin
      dat_src[20 + 2*p] = serial_port_data_a_out[p];
      dat_src[21 + 2*p] = serial_port_data_b_out[p];
    end
    dat_src[35:32] = rate_converter_data_out;
    dat_src[39:36] = rate_converter_tdm_out;
    dat_src[40]    = spdif_rx_data_out;
    dat_src[44]    = serial_port_data_a_out[6];
    dat_src[45]    = serial_port_data_b_out[6];
    dat_src[46]    = serial_port_data_a_out[7];
    dat_src[47]    = serial_port_data_b_out[7];
    dat_src[48]    = spdif_tx_biphase_out;
    dat_src[62]    = 1'b0;
    dat_src[63]    = 1'b1;
  end

  // Frame sync group; code 0x1B reserved and low
  assign fs_src = {1'b1, 1'b0,
                   precision_frame_sync_out[1],
                   precision_frame_sync_out[0],
                   1'b0,
                   spdif_rx_frame_sync_out,
                   serial_port_frame_sync_out[5:0],
                   pin_src};

  // Pin assignment group
  always_comb begin
    pin_assign_src = 128'h0; // Reserved codes drive low
    pin_assign_src[19:0] = pin_src;
    for (int p = 0; p < 6; p++) begin
      pin_assign_src[20 + 2*p] = serial_port_data_a_out[p];
      pin_assign_src[21 + 2*p] = serial_port_data_b_out[p];
      pin_assign_src[32 + p]   = serial_port_clock_out[p];
      pin_assign_src[38 + p]   = serial_port_frame_sync_out[p];
    end
    pin_assign_src[44]     = serial_port_data_a_out[6];
    pin_assign_src[45]     = serial_port_data_b_out[6];
    pin_assign_src[46]     = serial_port_data_a_out[7];
    pin_assign_src[47]     = serial_port_data_b_out[7];
    pin_assign_src[48]     = parallel_strobe_out;
    pin_assign_src[49]     = spdif_tx_block_start_out;
    // Port 6 and 7 clocks and syncs leave only through pins
    pin_assign_src[52]     = serial_port_clock_out[6];
    pin_assign_src[53]     = serial_port_clock_out[7];
    pin_assign_src[54]     = serial_port_frame_sync_out[6];
    pin_assign_src[55]     = serial_port_frame_sync_out[7];
    pin_assign_src[56]     = precision_clock_out[0];
    pin_assign_src[57]     = precision_clock_out[1];
    pin_assign_src[58]     = precision_frame_sync_out[0];
    pin_assign_src[59]     = precision_frame_sync_out[1];
    pin_assign_src[64:61]  = rate_converter_data_out;
    pin_assign_src[65]     = spdif_rx_data_out;
    pin_assign_src[66]     = spdif_rx_frame_sync_out;
    pin_assign_src[67]     = spdif_rx_clock_out;
    pin_assign_src[68]     = spdif_rx_tdm_clock_out;
    pin_assign_src[69]     = spdif_tx_biphase_out;
    pin_assign_src[77:70]  = serial_port_tx_valid_out;
    pin_assign_src[78]     = spdif_rx_lrclk_ref_out;
    pin_assign_src[79]     = spdif_rx_lrclk_fb_out;
    pin_assign_src[80]     = precision_clock_out[2];
    pin_assign_src[81]     = precision_clock_out[3];
    pin_assign_src[82]     = precision_frame_sync_out[2];
    pin_assign_src[83]     = precision_frame_sync_out[3];
    pin_assign_src[126]    = 1'b0;
    pin_assign_src[127]    = 1'b1;
  end

  // ****************************************************************
  // Routing multiplexers
  // ****************************************************************
  // Muxes are left unregistered: routed audio clocks must not be resampled
  genvar gi;
  generate
    for (gi = 0; gi < NCLK; gi++) begin : g_clk
      assign clock_route_out[gi] = pick32(clk_src,
        st_r.regs[`ARM_CLK_IDX0 + gi / `ARM_CLK_FPR]
                 [(gi % `ARM_CLK_FPR) * `ARM_CLK_FW +: `ARM_CLK_FW]);
    end
    for (gi = 0; gi < NDAT; gi++) begin : g_dat
      assign data_route_out[gi] = pick64(dat_src,
        st_r.regs[`ARM_DAT_IDX0 + gi / `ARM_DAT_FPR]
                 [(gi % `ARM_DAT_FPR) * `ARM_DAT_FW +: `ARM_DAT_FW]);
    end
    for (gi = 0; gi < NFS; gi++) begin : g_fs
      assign frame_sync_route_out[gi] = pick32(fs_src,
        st_r.regs[`ARM_FS_IDX0 + gi / `ARM_FS_FPR]
                 [(gi % `ARM_FS_FPR) * `ARM_FS_FW +: `ARM_FS_FW]);
    end
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign pin_buffer_out[gi] = pick128(pin_assign_src,
        st_r.regs[`ARM_PIN_IDX0 + gi / `ARM_PIN_FPR]
                 [(gi % `ARM_PIN_FPR) * `ARM_PIN_FW +: `ARM_PIN_FW]);
    end
  endgenerate

  // Generator external clocks: fourth clock register, fields 0 and 1
  localparam int PCGA_DEST = 3 * `ARM_CLK_FPR + `ARM_PCGA_FIELD;
  localparam int PCGB_DEST = 3 * `ARM_CLK_FPR + `ARM_PCGB_FIELD;
  assign pcg_ext_clock_a = clock_route_out[PCGA_DEST];
  assign pcg_ext_clock_b = clock_route_out[PCGB_DEST];

endmodule

// *** arm_routing_matrix_chk.sv ***
`timescale 1ns/1ns

// ************************************************************
// Port checker for the routing matrix
// ************************************************************
module arm_routing_matrix_chk (
  input logic               core_clk,
  input logic               rst,
  input arm_pkg::arm_addr_t addr,
  input arm_pkg::arm_word_t wr_data,
  input logic               wr_en,
  input logic               rd_en,
  input arm_pkg::arm_word_t rd_data,
  input logic [19:0]        pin_in,
  input logic [7:0]         serial_port_clock_out,
  input logic [3:0]         precision_clock_out,
  input logic               spdif_tx_biphase_out,
  input logic [35:0]        clock_route_out,
  input logic [29:0]        data_route_out,
  input logic [19:0]        pin_buffer_out,
  input logic               pcg_ext_clock_a,
  input logic               pcg_ext_clock_b
);
  import arm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Writes to the three watched select words
  sequence s_wr_clk3;
    wr_en && addr == 8'h0c;
  endsequence
  sequence s_wr_dat1;
    wr_en && addr == 8'h18;
  endsequence
  sequence s_wr_pin4;
    wr_en && addr == 8'h54;
  endsequence
  // Biphase picked for pin 17, then a quiet cycle so nothing re-routes it
  sequence s_set_biphase;
    s_wr_pin4 ##0 wr_data[6:0] == 7'h45 ##1 !wr_en;
  endsequence

  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data not zero outside the answer cycle");
  AST_PCG_TAP: assert property (
    pcg_ext_clock_a == clock_route_out[18] && pcg_ext_clock_b == clock_route_out[19])
    else $error("generator clock taps differ from clock register 3");
  AST_CLK_CONST: assert property (
    s_wr_clk3 ##0 wr_data[4:1] == 4'hf |=> pcg_ext_clock_a == $past(wr_data[0]))
    else $error("constant clock code not honoured");
  AST_CLK_PIN: assert property (
    s_wr_clk3 ##0 wr_data[4:0] < 5'h12 |=> pcg_ext_clock_a == pin_in[$past(wr_data[4:0])])
    else $error("clock pin code picks wrong pin");
  AST_CLK_PORT: assert property (
    s_wr_clk3 ##0 wr_data[9:5] inside {[5'h14:5'h19]}
    |=> pcg_ext_clock_b == serial_port_clock_out[$past(wr_data[9:5]) - 5'h14])
    else $error("clock port code picks wrong serial port");
  AST_CLK_GEN: assert property (
    s_wr_clk3 ##0 wr_data[4:1] == 4'he
    |=> pcg_ext_clock_a == precision_clock_out[$past(wr_data[0])])
    else $error("clock generator code picks wrong generator");
  AST_DAT_CONST: assert property (
    s_wr_dat1 ##0 wr_data[5:1] == 5'h1f |=> data_route_out[0] == $past(wr_data[0]))
    else $error("constant data code not honoured");
  AST_DAT_RSVD: assert property (
    s_wr_dat1 ##0 wr_data[5:0] inside {[6'h31:6'h3d]} |=> !data_route_out[0])
    else $error("reserved data code drives a level");
  AST_PIN_CONST: assert property (
    s_wr_pin4 ##0 wr_data[6:1] == 6'h3f |=> pin_buffer_out[16] == $past(wr_data[0]))
    else $error("constant pin code not honoured");
  // Pin 19 seen through pin 17, once with its inversion live, once looped on itself
  AST_PIN_INV: assert property (
    s_wr_pin4 ##0 wr_data[6:0] == 7'h12 && wr_data[20:14] == 7'h7e && wr_data[28]
    |=> pin_buffer_out[16] != pin_in[18])
    else $error("pin 19 input not inverted");
  AST_PIN_LOOP: assert property (
    s_wr_pin4 ##0 wr_data[6:0] == 7'h12 && wr_data[20:14] == 7'h12 && wr_data[28]
    |=> pin_buffer_out[16] == pin_in[18])
    else $error("looped pin 19 input was inverted");
  AST_PIN_LIVE: assert property (
    s_set_biphase |-> pin_buffer_out[16] == spdif_tx_biphase_out
    ##1 pin_buffer_out[16] == spdif_tx_biphase_out)
    else $error("pin route lags its source");
endmodule

bind arm_routing_matrix arm_routing_matrix_chk i_arm_routing_matrix_chk (
  .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
  .serial_port_clock_out(serial_port_clock_out), .precision_clock_out(precision_clock_out),
  .spdif_tx_biphase_out(spdif_tx_biphase_out), .clock_route_out(clock_route_out),
  .data_route_out(data_route_out), .pin_buffer_out(pin_buffer_out),
  .pcg_ext_clock_a(pcg_ext_clock_a), .pcg_ext_clock_b(pcg_ext_clock_b)
);

// *** arm_periph_model.sv ***
`timescale 1ns/1ns

// ************************************************************
// Far-side peripherals as one flat vector of outputs
// ************************************************************
module arm_periph_model (
  input  logic        core_clk,
  input  logic [64:0] stim,
  output logic [64:0] src
);
  // Outputs copy stim one clock late, so a stale or pipelined route shows up
  always @(posedge core_clk) begin
    src <= stim;
  end
endmodule

// *** arm_routing_matrix_tb_top.sv ***
`timescale 1ns/1ns
`include "arm_consts.svh"

`define CHK(got, exp, what) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH %0t %s", $time, what); \
    end \
  end

module arm_routing_matrix_tb_top;
  import arm_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  arm_addr_t   addr = '0;
  arm_word_t   wr_data = '0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  arm_word_t   rd_data;
  logic [19:0] pin_in = '1; // High in reset: only parked codes give zero
  logic [64:0] stim = '1;
  logic [64:0] src;
  logic [35:0] clk_o;
  logic [29:0] dat_o;
  logic [29:0] fs_o;
  logic [19:0] pin_o;
  logic        pcg_a;
  logic        pcg_b;
  int          seed = 27689;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  arm_word_t   d;
  // Pin codes 0x30-0x53 as places in the source vector, -1 where reserved
  localparam int PIN_MAP [36] = '{56, 55, -1, -1, 6, 7, 14, 15, 57, 58, 61, 62, -1, 40, 41,
    42, 43, 50, 51, 48, 49, 54, 32, 33, 34, 35, 36, 37, 38, 39, 52, 53, 59, 60, 63, 64};

  always #10 core_clk = ~core_clk;

  arm_periph_model i_arm_periph_model (.core_clk(core_clk), .stim(stim), .src(src));

  arm_routing_matrix i_arm_routing_matrix (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
    .serial_port_clock_out(src[7:0]), .serial_port_frame_sync_out(src[15:8]),
    .serial_port_data_a_out(src[23:16]), .serial_port_data_b_out(src[31:24]),
    .serial_port_tx_valid_out(src[39:32]), .rate_converter_data_out(src[43:40]),
    .rate_converter_tdm_out(src[47:44]), .spdif_rx_clock_out(src[48]),
    .spdif_rx_tdm_clock_out(src[49]), .spdif_rx_data_out(src[50]),
    .spdif_rx_frame_sync_out(src[51]), .spdif_rx_lrclk_ref_out(src[52]),
    .spdif_rx_lrclk_fb_out(src[53]), .spdif_tx_biphase_out(src[54]),
    .spdif_tx_block_start_out(src[55]), .parallel_strobe_out(src[56]),
    .precision_clock_out(src[60:57]), .precision_frame_sync_out(src[64:61]),
    .clock_route_out(clk_o), .data_route_out(dat_o), .frame_sync_route_out(fs_o),
    .pin_buffer_out(pin_o), .pcg_ext_clock_a(pcg_a), .pcg_ext_clock_b(pcg_b)
  );

  // ************************************************************
  // Expected levels per group
  // ************************************************************
  function automatic logic exp5(input logic [4:0] c, input logic fs);
    if (c < 5'h14) return pin_in[c];
    if (c < 5'h1a) return src[int'(c) - 20 + (fs ? 8 : 0)];
    case (c)
      5'h1a: return src[fs ? 51 : 48];
      5'h1b: return fs ? 1'b0 : src[49];
      5'h1c: return src[fs ? 61 : 57];
      5'h1d: return src[fs ? 62 : 58];
      default: return c[0];
    endcase
  endfunction

  function automatic logic exp6(input logic [5:0] c);
    int p;
    p = int'(c);
    if (p < 20) return pin_in[p];
    if (p < 32) return src[(p[0] ? 24 : 16) + (p - 20) / 2];
    if (p < 40) return src[p + 8];
    if (p == 40) return src[50];
    if (p >= 44 && p < 48) return src[(p[0] ? 24 : 16) + 6 + (p - 44) / 2];
    if (p == 48) return src[54];
    return p == 63;
  endfunction

  function automatic logic exp7(input logic [6:0] c);
    int p;
    p = int'(c);
    if (p < 32 || (p >= 44 && p < 48)) return exp6(c[5:0]);
    if (p < 38) return src[p - 32];
    if (p < 44) return src[p - 30];
    if (p < 84 && PIN_MAP[p - 48] >= 0) return src[PIN_MAP[p - 48]];
    return p == 127;
  endfunction

  function automatic arm_word_t rst_val(input int i);
    return i < 12 ? (i < 6 ? `ARM_CLK_RST : `ARM_DAT_RST) : i < 17 ? `ARM_FS_RST : 32'h0;
  endfunction

  // ************************************************************
  // Register port tasks
  // ************************************************************
  // Fresh source levels launch with every write, so each route sees new data
  task automatic wr(input arm_addr_t a, input arm_word_t v);
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    @(posedge core_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    stim <= r[64:0];
    pin_in <= r[95:76];
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input arm_addr_t a, output arm_word_t v);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    v = rd_data;
  endtask

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 670 cycles of the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK({clk_o, dat_o, fs_o, pin_o}, 116'h0, "routes after reset")
    for (int i = 0; i < 23; i++) begin
      rd(arm_addr_t'(i * 4), d);
      `CHK(d, (i > 16 && i < 22) ? `ARM_PIN_RST : rst_val(i), "reset value")
    end
    for (int i = 0; i < 22; i++) begin
      wr(arm_addr_t'(i * 4), 32'hffffffff);
      rd(arm_addr_t'(i * 4), d);
      `CHK(d, (i == 21 || i < 17) ? `ARM_MASK30 : `ARM_MASK28, "stored bits")
    end
    wr(8'h58, 32'h0);
    rd(8'h58, d);
    `CHK(d, 32'h3, "inversion status")
    rd(8'h5c, d);
    `CHK(d, 32'h0, "unmapped read")
    rd(8'h0d, d);
    `CHK(d, 32'h0, "misaligned read")
    // Reset in mid-run must bring the parked codes back
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h54, d);
    `CHK(d, `ARM_PIN_RST, "second reset")
    // Every select was all ones before this reset, so a stale code shows high
    `CHK({clk_o, dat_o, fs_o, pin_o}, 116'h0, "routes after second reset")
    for (int c = 0; c < 32; c++) begin
      wr(8'h0c, {22'h0, c[4:0], c[4:0]});
      `CHK({pcg_a, pcg_b}, {2{exp5(c[4:0], 1'b0)}}, "clock route")
      wr(8'h30, {27'h0, c[4:0]});
      `CHK(fs_o[0], exp5(c[4:0], 1'b1), "frame sync route")
    end
    for (int c = 0; c < 64; c++) begin
      wr(8'h18, {20'h0, c[5:0], c[5:0]});
      `CHK(dat_o[1:0], {2{exp6(c[5:0])}}, "data route")
    end
    for (int c = 0; c < 128; c++) begin
      wr(8'h54, {25'h0, c[6:0]});
      `CHK(pin_o[16], exp7(c[6:0]), "pin route")
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h54, 32'h1 << (28 + k) | 32'h7e << (14 + 7 * k) | (32'h12 + k));
      `CHK(pin_o[16], ~pin_in[18 + k], "inverted pin input")
      wr(8'h54, 32'h1 << (28 + k) | (32'h12 + k) << (14 + 7 * k) | (32'h12 + k));
      `CHK(pin_o[16], pin_in[18 + k], "looped pin input")
    end
    summarize();
  end
endmodule
